// >>> include/sfr_map.svh
// Register map, field positions, reset values and masks of the special-function block
// Operation
// - Bank bit zero picks bank zero or one
// - Pointer zero and direct accesses hit bank zero
// - Pointer one accesses follow the bank bit
// - Resets clear bank, except watchdog reset in halt
// - Special registers decode independent of bank bit
// - Status writes never touch expired or halt flags
// - Expired flag: set on timeout, clear otherwise listed
// - Halt flag: set by halt, cleared by power/clear
// - Sign-wrap flag is carry-in xor carry-out of msb
// - Zero flag follows zero result
// - Nibble carry is carry out of low nibble
// - Carry is add carry, no-borrow, or rotate bit
// - No automatic status save on interrupt or call
// - Direction bit one means input, zero output
// - Divider enable field decode, reserved code disables
// - Control bit six picks divider timer source
// - Control bit one sets slow crystal low power
// - Control bit zero selects slow crystal clock
// - Control bit seven remaps interrupt, timer, divider pins
// - Control bit five picks pwm split format
// - Control bits four to two route pins
// - Any pwm pin forces timer clock from system
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
`define ADDR_PORT_ZERO 8'h00
`define ADDR_PTR_ZERO 8'h01
`define ADDR_PORT_ONE 8'h02
`define ADDR_PTR_ONE 8'h03
`define ADDR_BANK 8'h04
`define ADDR_STATUS 8'h0a
`define ADDR_PORT_DIR 8'h11
`define ADDR_CTRL_A 8'h1a
`define SFR_LIMIT 8'h40
`define BANK_BIT 0
`define TO_BIT 5
`define PDF_BIT 4
`define CTL_REMAP 7
`define CTL_DIVSRC 6
`define CTL_PWMFMT 5
`define CTL_PWM1 4
`define CTL_PWM0 3
`define CTL_DIVPIN 2
`define CTL_DIVEN_HI 3
`define CTL_DIVEN_LO 2
`define CTL_SLOW_CRYSTAL_LOW_POWER 1
`define CTL_CLKSEL 0
`define BANK_RST 8'h00
`define STATUS_RST 8'h00
`define CTRL_RST 8'h00
`define PTR_RST 8'h00
`define PORT_DIR_RST 8'hff
`define BANK_MASK 8'h01
`define STATUS_SW_MASK 8'h0f
`define CTRL_SMALL_MASK 8'h0f
`define CTRL_DIVSRC_MASK 8'h40
`define CTRL_FULL_MASK 8'hff
`endif

// >>> include/sfr_pkg.sv
// Types shared by the special-function block
package sfr_pkg;
  typedef enum logic [1:0] {
    ROUTE_DIRECT,
    ROUTE_PTR0,
    ROUTE_PTR1
  } route_t;
  typedef logic [7:0] byte_t;
endpackage

// >>> include/sfr_flags_if.sv
// Signals between the register block and the status flag unit
`timescale 1ns/1ps
`default_nettype none
interface sfr_flags_if;
  logic sw_we;
  logic [7:0] sw_wdata;
  logic [3:0] alu_upd;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic [7:0] alu_result;
  logic alu_rotate;
  logic alu_rot_carry;
  logic wdt_timeout;
  logic watchdog_clear_instruction_exec;
  logic halt_exec;
  logic power_up;
  logic [7:0] status;
  modport regs (
    output sw_we, sw_wdata, alu_upd, alu_a, alu_b, alu_cin, alu_result,
    output alu_rotate, alu_rot_carry, wdt_timeout, watchdog_clear_instruction_exec, halt_exec, power_up,
    input status
  );
  modport unit (
    input sw_we, sw_wdata, alu_upd, alu_a, alu_b, alu_cin, alu_result,
    input alu_rotate, alu_rot_carry, wdt_timeout, watchdog_clear_instruction_exec, halt_exec, power_up,
    output status
  );
endinterface
`default_nettype wire

// >>> verilog/cpu_flags_unit.sv
// Status flag register with arithmetic flag generation
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map.svh"
module cpu_flags_unit
  import sfr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  sfr_flags_if.unit fl
);
  logic [7:0] status_r;
  wire logic [7:0] status_nxt;
  wire logic [7:0] status_rst;
  wire logic [4:0] sum_lo;
  wire logic [7:0] sum_7;
  wire logic [8:0] sum_8;
  wire logic [3:0] calc;
  wire logic to_nxt;
  wire logic pdf_nxt;
  wire logic pwr_clr;
  assign sum_lo = {1'b0, fl.alu_a[3:0]} + {1'b0, fl.alu_b[3:0]} + {4'h0, fl.alu_cin};
  assign sum_7 = {1'b0, fl.alu_a[6:0]} + {1'b0, fl.alu_b[6:0]} + {7'h00, fl.alu_cin};
  assign sum_8 = {1'b0, fl.alu_a} + {1'b0, fl.alu_b} + {8'h00, fl.alu_cin};
  assign calc[0] = fl.alu_rotate ? fl.alu_rot_carry : sum_8[8];
  assign calc[1] = sum_lo[4];
  assign calc[2] = (fl.alu_result == 8'h00);
  assign calc[3] = sum_7[7] ^ sum_8[8];
  assign pwr_clr = !rst_b && fl.power_up;
  assign status_rst = `STATUS_RST;
  // Timeout set wins over any clear in the same cycle
  assign to_nxt = fl.wdt_timeout |
    (status_r[`TO_BIT] & ~(fl.watchdog_clear_instruction_exec | fl.halt_exec | pwr_clr));
  assign pdf_nxt = fl.halt_exec | (status_r[`PDF_BIT] & ~(fl.watchdog_clear_instruction_exec | pwr_clr));
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_arith
      // Software write wins, then the result of this cycle
      assign status_nxt[i] = (!rst_b) ? status_rst[i] :
        fl.sw_we ? fl.sw_wdata[i] : fl.alu_upd[i] ? calc[i] : status_r[i];
    end
  endgenerate
  assign status_nxt[`PDF_BIT] = pdf_nxt;
  assign status_nxt[`TO_BIT] = to_nxt;
  assign status_nxt[7:6] = 2'b00;
  always_ff @(posedge clk_sys) begin
    status_r <= status_nxt;
  end
  assign fl.status = status_r;
endmodule
`default_nettype wire

// >>> verilog/mcu_sfr.sv
// Special-function register block: banking, pointers, status, port direction, control
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map.svh"
module mcu_sfr
  import sfr_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1,
  parameter bit HAS_DIV_SOURCE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_power_up,
  input wire logic reset_wdt_in_halt,
  input wire logic [7:0] acc_addr,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic [3:0] alu_upd,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic alu_cin,
  input wire logic [7:0] alu_result,
  input wire logic alu_rotate,
  input wire logic alu_rot_carry,
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_instruction_exec,
  input wire logic halt_exec,
  input wire logic cfg_rc_plus_crystal,
  input wire logic pwm2_pin_enable,
  output logic [7:0] rdata_r,
  output logic rd_valid_r,
  output logic ram_req_r,
  output logic ram_we_r,
  output logic ram_bank_r,
  output logic [7:0] ram_addr_r,
  output logic [7:0] ram_wdata_r,
  output logic [7:0] port_output_en_r,
  output logic div_out_first_en_r,
  output logic div_out_second_en_r,
  output logic div_src_timer1_r,
  output logic slow_crystal_low_power_r,
  output logic sys_clk_from_lxt_r,
  output logic fast_osc_stop_r,
  output logic pin_remap_port_b_r,
  output logic pwm_format_7p1_r,
  output logic pwm_zero_pin_en_r,
  output logic pwm_one_pin_en_r,
  output logic div_pin_en_r,
  output logic timer_clk_from_sys_r
);
  sfr_flags_if fl ();

  logic [7:0] ptr_zero_r;
  logic [7:0] ptr_one_r;
  logic [7:0] bank_select_r;
  logic [7:0] port_dir_r;
  logic [7:0] ctrl_a_r;
  logic [7:0] bank_select_nxt;
  logic [7:0] ptr_zero_nxt;
  logic [7:0] ptr_one_nxt;
  logic [7:0] port_dir_nxt;
  logic [7:0] ctrl_a_nxt;

  wire route_t route;
  wire logic [7:0] eff_addr;
  wire logic eff_bank;
  wire logic sfr_hit;
  wire logic sfr_wr;
  wire logic wr_ptr_zero;
  wire logic wr_ptr_one;
  wire logic wr_bank;
  wire logic wr_status;
  wire logic wr_port_dir;
  wire logic wr_ctrl;
  wire logic [7:0] ctrl_mask;
  wire logic [7:0] bank_mask;
  wire logic [7:0] rd_data;
  wire logic bank_bit;
  wire logic [1:0] div_en_field;
  wire logic div_first_nxt;
  wire logic div_second_nxt;
  wire logic lxt_select;
  wire logic any_pwm_pin;

  // Address routing through the two indirect ports
  assign route = (acc_addr == `ADDR_PORT_ZERO) ? ROUTE_PTR0 :
                 (acc_addr == `ADDR_PORT_ONE) ? ROUTE_PTR1 : ROUTE_DIRECT;
  assign eff_addr = (route == ROUTE_PTR0) ? ptr_zero_r :
                    (route == ROUTE_PTR1) ? ptr_one_r : acc_addr;
  assign bank_bit = FULL_VARIANT & bank_select_r[`BANK_BIT];
  // Pointer zero and direct addressing stay in bank zero
  assign eff_bank = (route == ROUTE_PTR1) ? bank_bit : 1'b0;
  // Special registers ignore the bank bit entirely
  assign sfr_hit = (eff_addr < `SFR_LIMIT);
  assign sfr_wr = acc_wr & sfr_hit;

  // Register write decode
  assign wr_ptr_zero = sfr_wr & (eff_addr == `ADDR_PTR_ZERO);
  assign wr_ptr_one = sfr_wr & (eff_addr == `ADDR_PTR_ONE);
  assign wr_bank = sfr_wr & (eff_addr == `ADDR_BANK) & FULL_VARIANT;
  assign wr_status = sfr_wr & (eff_addr == `ADDR_STATUS);
  assign wr_port_dir = sfr_wr & (eff_addr == `ADDR_PORT_DIR);
  assign wr_ctrl = sfr_wr & (eff_addr == `ADDR_CTRL_A);

  // Implemented bits per variant
  assign ctrl_mask = FULL_VARIANT ? `CTRL_FULL_MASK :
                     (`CTRL_SMALL_MASK | (HAS_DIV_SOURCE ? `CTRL_DIVSRC_MASK : 8'h00));
  assign bank_mask = FULL_VARIANT ? `BANK_MASK : 8'h00;

  // Read data, unused locations read as zero
  assign rd_data = (eff_addr == `ADDR_PTR_ZERO) ? ptr_zero_r :
                   (eff_addr == `ADDR_PTR_ONE) ? ptr_one_r :
                   (eff_addr == `ADDR_BANK) ? (bank_select_r & bank_mask) :
                   (eff_addr == `ADDR_STATUS) ? fl.status :
                   (eff_addr == `ADDR_PORT_DIR) ? port_dir_r :
                   (eff_addr == `ADDR_CTRL_A) ? (ctrl_a_r & ctrl_mask) : 8'h00;

  // Next values of the software registers
  always_comb begin
    ptr_zero_nxt = ptr_zero_r;
    ptr_one_nxt = ptr_one_r;
    bank_select_nxt = bank_select_r;
    port_dir_nxt = port_dir_r;
    ctrl_a_nxt = ctrl_a_r;
    if (wr_ptr_zero) begin
      ptr_zero_nxt = acc_wdata;
    end
    if (wr_ptr_one) begin
      ptr_one_nxt = acc_wdata;
    end
    if (wr_bank) begin
      bank_select_nxt = acc_wdata & bank_mask;
    end
    if (wr_port_dir) begin
      port_dir_nxt = acc_wdata;
    end
    if (wr_ctrl) begin
      ctrl_a_nxt = acc_wdata & ctrl_mask;
    end
  end

  // Bank keeps its value across a watchdog reset taken in halt
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      if (!reset_wdt_in_halt) begin
        bank_select_r <= `BANK_RST;
      end
    end else begin
      bank_select_r <= bank_select_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ptr_zero_r <= `PTR_RST;
    end else begin
      ptr_zero_r <= ptr_zero_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ptr_one_r <= `PTR_RST;
    end else begin
      ptr_one_r <= ptr_one_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      port_dir_r <= `PORT_DIR_RST;
    end else begin
      port_dir_r <= port_dir_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_a_r <= `CTRL_RST;
    end else begin
      ctrl_a_r <= ctrl_a_nxt;
    end
  end

  // Status flags live in the flag unit; nothing is stacked on calls
  assign fl.sw_we = wr_status & rst_b;
  assign fl.sw_wdata = acc_wdata & `STATUS_SW_MASK;
  assign fl.alu_upd = rst_b ? alu_upd : 4'h0;
  assign fl.alu_a = alu_a;
  assign fl.alu_b = alu_b;
  assign fl.alu_cin = alu_cin;
  assign fl.alu_result = alu_result;
  assign fl.alu_rotate = alu_rotate;
  assign fl.alu_rot_carry = alu_rot_carry;
  assign fl.wdt_timeout = wdt_timeout;
  assign fl.watchdog_clear_instruction_exec = watchdog_clear_instruction_exec;
  assign fl.halt_exec = halt_exec;
  assign fl.power_up = reset_power_up;

  // Status holds only what software, the core and the watchdog put there
  cpu_flags_unit u_flags (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fl(fl)
  );

  // Data path towards the core and the general memory
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= (acc_rd & sfr_hit) ? rd_data : 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= acc_rd & sfr_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_req_r <= 1'b0;
    end else begin
      ram_req_r <= (acc_rd | acc_wr) & ~sfr_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_we_r <= 1'b0;
    end else begin
      ram_we_r <= acc_wr & ~sfr_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_bank_r <= 1'b0;
    end else begin
      ram_bank_r <= eff_bank;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_addr_r <= 8'h00;
    end else begin
      ram_addr_r <= eff_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_wdata_r <= 8'h00;
    end else begin
      ram_wdata_r <= acc_wdata;
    end
  end

  // Control field decode
  assign div_en_field = {ctrl_a_r[`CTL_DIVEN_HI], ctrl_a_r[`CTL_DIVEN_LO]};
  // Reserved code 01 is treated as both disabled
  assign div_first_nxt = FULL_VARIANT ? ctrl_a_r[`CTL_DIVPIN] :
                         (div_en_field == 2'b10) | (div_en_field == 2'b11);
  assign div_second_nxt = FULL_VARIANT ? 1'b0 : (div_en_field == 2'b11);
  assign lxt_select = ctrl_a_r[`CTL_CLKSEL] & (FULL_VARIANT | cfg_rc_plus_crystal);
  assign any_pwm_pin = FULL_VARIANT &
    (ctrl_a_r[`CTL_PWM0] | ctrl_a_r[`CTL_PWM1] | pwm2_pin_enable);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      port_output_en_r <= 8'h00;
    end else begin
      port_output_en_r <= ~port_dir_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_out_first_en_r <= 1'b0;
    end else begin
      div_out_first_en_r <= div_first_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_out_second_en_r <= 1'b0;
    end else begin
      div_out_second_en_r <= div_second_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_pin_en_r <= 1'b0;
    end else begin
      div_pin_en_r <= FULL_VARIANT & ctrl_a_r[`CTL_DIVPIN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_src_timer1_r <= 1'b0;
      slow_crystal_low_power_r <= 1'b0;
    end else begin
      div_src_timer1_r <= (FULL_VARIANT | HAS_DIV_SOURCE) & ctrl_a_r[`CTL_DIVSRC];
      slow_crystal_low_power_r <= ctrl_a_r[`CTL_SLOW_CRYSTAL_LOW_POWER];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sys_clk_from_lxt_r <= 1'b0;
      fast_osc_stop_r <= 1'b0;
    end else begin
      sys_clk_from_lxt_r <= lxt_select;
      fast_osc_stop_r <= lxt_select;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_remap_port_b_r <= 1'b0;
      pwm_format_7p1_r <= 1'b0;
    end else begin
      pin_remap_port_b_r <= FULL_VARIANT & ctrl_a_r[`CTL_REMAP];
      pwm_format_7p1_r <= FULL_VARIANT & ctrl_a_r[`CTL_PWMFMT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pwm_zero_pin_en_r <= 1'b0;
      pwm_one_pin_en_r <= 1'b0;
      timer_clk_from_sys_r <= 1'b0;
    end else begin
      pwm_zero_pin_en_r <= FULL_VARIANT & ctrl_a_r[`CTL_PWM0];
      pwm_one_pin_en_r <= FULL_VARIANT & ctrl_a_r[`CTL_PWM1];
      timer_clk_from_sys_r <= any_pwm_pin;
    end
  end
endmodule
`default_nettype wire

// >>> tb/mcu_sfr_chk.sv
// Concurrent checks on the special-function block ports
`timescale 1ns/1ps
`default_nettype none
module mcu_sfr_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] acc_addr,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic wdt_timeout,
  input wire logic watchdog_clear_instruction_exec,
  input wire logic halt_exec,
  input wire logic [7:0] rdata_r,
  input wire logic rd_valid_r,
  input wire logic ram_req_r,
  input wire logic ram_bank_r,
  input wire logic [7:0] ram_addr_r,
  input wire logic [7:0] port_output_en_r,
  input wire logic pwm_zero_pin_en_r,
  input wire logic pwm_one_pin_en_r,
  input wire logic timer_clk_from_sys_r
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_read_bank: assert property (
    acc_rd && acc_addr == 8'h04 |=> rd_valid_r && rdata_r[7:1] == 7'h00)
    else $error("bank read wrong");
  a_ptr_zero_bank: assert property (
    (acc_rd || acc_wr) && acc_addr == 8'h00 |=> !(ram_req_r && ram_bank_r))
    else $error("pointer zero left bank zero");
  a_direct_bank_zero: assert property (
    (acc_rd || acc_wr) && acc_addr >= 8'h40
    |=> ram_req_r && !ram_bank_r && ram_addr_r == $past(acc_addr))
    else $error("direct access wrong");
  a_sfr_no_ram: assert property (
    (acc_rd || acc_wr) && acc_addr < 8'h40 && acc_addr != 8'h00 && acc_addr != 8'h02
    |=> !ram_req_r) else $error("special register went to memory");
  a_dir_output: assert property (
    acc_wr && acc_addr == 8'h11 ##1 !(acc_wr && acc_addr == 8'h11)
    |=> port_output_en_r == ~$past(acc_wdata, 2)) else $error("direction wrong");
  a_halt_flags: assert property (
    halt_exec && !watchdog_clear_instruction_exec && !wdt_timeout ##1 acc_rd && acc_addr == 8'h0a
    && !watchdog_clear_instruction_exec && !wdt_timeout |=> rdata_r[5:4] == 2'b01) else $error("halt flags");
  a_timeout_flag: assert property (
    wdt_timeout ##1 acc_rd && acc_addr == 8'h0a && !watchdog_clear_instruction_exec && !halt_exec
    |=> rdata_r[5]) else $error("timeout flag");
  a_pwm_sys_clk: assert property (
    pwm_zero_pin_en_r || pwm_one_pin_en_r |-> timer_clk_from_sys_r)
    else $error("timer clock not system");
endmodule
bind mcu_sfr mcu_sfr_chk mcu_sfr_chk_i (.clk_sys, .rst_b, .acc_addr, .acc_rd, .acc_wr,
  .acc_wdata, .wdt_timeout, .watchdog_clear_instruction_exec, .halt_exec, .rdata_r, .rd_valid_r, .ram_req_r,
  .ram_bank_r, .ram_addr_r, .port_output_en_r, .pwm_zero_pin_en_r, .pwm_one_pin_en_r,
  .timer_clk_from_sys_r);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the special-function register block
`timescale 1ns/1ps
`default_nettype none
`include "sfr_map.svh"
module tb_top;
  logic clk_sys = 1'b0, rst_b = 1'b0, reset_power_up = 1'b1, reset_wdt_in_halt = 1'b0;
  logic acc_rd = 1'b0, acc_wr = 1'b0, alu_cin = 1'b0, alu_rotate = 1'b0;
  logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  logic [7:0] alu_result = 8'h00;
  logic [3:0] alu_upd = 4'h0;
  logic alu_rot_carry = 1'b0, wdt_timeout = 1'b0, watchdog_clear_instruction_exec = 1'b0, halt_exec = 1'b0;
  logic cfg_rc_plus_crystal = 1'b1, pwm2_pin_enable = 1'b0;
  logic [7:0] rdata_r, ram_addr_r, ram_wdata_r, port_output_en_r;
  logic rd_valid_r, ram_req_r, ram_we_r, ram_bank_r, div_out_first_en_r, div_out_second_en_r;
  logic div_src_timer1_r, slow_crystal_low_power_r, sys_clk_from_lxt_r, fast_osc_stop_r;
  logic pin_remap_port_b_r, pwm_format_7p1_r, pwm_zero_pin_en_r, pwm_one_pin_en_r;
  logic div_pin_en_r, timer_clk_from_sys_r;
  int n_errors = 0;
  int num_checks = 0;
  mcu_sfr mcu_sfr_i (.clk_sys, .rst_b, .reset_power_up, .reset_wdt_in_halt, .acc_addr,
    .acc_rd, .acc_wr, .acc_wdata, .alu_upd, .alu_a, .alu_b, .alu_cin, .alu_result,
    .alu_rotate, .alu_rot_carry, .wdt_timeout, .watchdog_clear_instruction_exec, .halt_exec,
    .cfg_rc_plus_crystal, .pwm2_pin_enable, .rdata_r, .rd_valid_r, .ram_req_r, .ram_we_r,
    .ram_bank_r, .ram_addr_r, .ram_wdata_r, .port_output_en_r, .div_out_first_en_r,
    .div_out_second_en_r, .div_src_timer1_r, .slow_crystal_low_power_r, .sys_clk_from_lxt_r,
    .fast_osc_stop_r, .pin_remap_port_b_r, .pwm_format_7p1_r, .pwm_zero_pin_en_r,
    .pwm_one_pin_en_r, .div_pin_en_r, .timer_clk_from_sys_r);
  always #5 clk_sys = ~clk_sys;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Request stays up until the next access changes it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    {acc_wr, acc_rd, acc_addr, acc_wdata} = {w, !w, a, d};
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, exp, rdata_r);
    chk("rd_valid", 8'h01, {7'h00, rd_valid_r});
  endtask
  task automatic ram(input logic [7:0] a, input logic b, input logic [7:0] ea);
    acc(1'b0, a, 8'h00);
    chk("ram_req", 8'h01, {7'h00, ram_req_r});
    chk("ram_bank", {7'h00, b}, {7'h00, ram_bank_r});
    chk("ram_addr", ea, ram_addr_r);
  endtask
  task automatic ev(input logic [2:0] v);
    {wdt_timeout, watchdog_clear_instruction_exec, halt_exec} = v;
    tick(1);
    {wdt_timeout, watchdog_clear_instruction_exec, halt_exec} = 3'b000;
  endtask
  task automatic reset(input logic pu, input logic wh);
    {acc_rd, acc_wr, reset_power_up, reset_wdt_in_halt, rst_b} = {2'b00, pu, wh, 1'b0};
    tick(2);
    rst_b = 1'b1;
  endtask
  task automatic t_reset();
    chk("dir_en", 8'h00, port_output_en_r);
    rd(`ADDR_BANK, 8'h00, "bank");
    rd(`ADDR_STATUS, 8'h00, "status");
    rd(`ADDR_CTRL_A, 8'h00, "ctrl");
    rd(`ADDR_PORT_DIR, 8'hff, "dir");
    acc(1'b1, `ADDR_PORT_DIR, 8'h3c);
    rd(`ADDR_PORT_DIR, 8'h3c, "dir");
    chk("dir_en", 8'hc3, port_output_en_r);
  endtask
  task automatic t_bank();
    acc(1'b1, `ADDR_BANK, 8'hff);
    rd(`ADDR_BANK, 8'h01, "bank");
    acc(1'b1, `ADDR_PTR_ONE, 8'h55);
    acc(1'b1, `ADDR_PTR_ZERO, 8'h66);
    ram(`ADDR_PORT_ONE, 1'b1, 8'h55);
    ram(`ADDR_PORT_ZERO, 1'b0, 8'h66);
    ram(8'h7e, 1'b0, 8'h7e);
    rd(`ADDR_PTR_ONE, 8'h55, "ptr_one");
    rd(8'h3f, 8'h00, "unused");
    acc(1'b1, 8'h40, 8'h9a);
    chk("ram_wdata", 8'h9a, ram_wdata_r);
    chk("ram_we", 8'h01, {7'h00, ram_we_r});
    acc(1'b1, `ADDR_BANK, 8'h00);
    ram(`ADDR_PORT_ONE, 1'b0, 8'h55);
  endtask
  task automatic t_flags();
    acc(1'b1, `ADDR_STATUS, 8'hff);
    rd(`ADDR_STATUS, 8'h0f, "status_wr");
    ev(3'b001);
    rd(`ADDR_STATUS, 8'h1f, "halt");
    acc(1'b1, `ADDR_STATUS, 8'h00);
    rd(`ADDR_STATUS, 8'h10, "status_wr");
    ev(3'b100);
    rd(`ADDR_STATUS, 8'h30, "timeout");
    ev(3'b001);
    rd(`ADDR_STATUS, 8'h10, "halt");
    ev(3'b100);
    rd(`ADDR_STATUS, 8'h30, "timeout");
    ev(3'b010);
    rd(`ADDR_STATUS, 8'h00, "clear");
    acc(1'b1, `ADDR_STATUS, 8'h30);
    rd(`ADDR_STATUS, 8'h00, "status_wr");
    ev(3'b101);
    rd(`ADDR_STATUS, 8'h30, "set_wins");
    ev(3'b010);
    rd(`ADDR_STATUS, 8'h00, "clear");
  endtask
  task automatic t_alu();
    logic [7:0] av[4] = '{8'h7f, 8'hff, 8'h08, 8'h05};
    logic [7:0] bv[4] = '{8'h01, 8'h01, 8'h08, 8'hf9};
    logic [7:0] rv[4] = '{8'h80, 8'h00, 8'h10, 8'hff};
    logic [3:0] fv[4] = '{4'ha, 4'h7, 4'h2, 4'h0};
    for (int i = 0; i < 4; i++) begin
      {alu_a, alu_b, alu_cin, alu_result, alu_upd} = {av[i], bv[i], i == 3, rv[i], 4'hf};
      tick(1);
      alu_upd = 4'h0;
      rd(`ADDR_STATUS, {4'h0, fv[i]}, "flags");
    end
    {alu_rotate, alu_rot_carry, alu_upd} = {2'b11, 4'h1};
    tick(1);
    {alu_rotate, alu_upd} = {1'b0, 4'h0};
    rd(`ADDR_STATUS, 8'h01, "rotate");
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, `ADDR_CTRL_A, 8'h01 << i);
      rd(`ADDR_CTRL_A, 8'h01 << i, "ctrl");
      chk("ctrl_out", 8'h01 << i, {pin_remap_port_b_r, div_src_timer1_r, pwm_format_7p1_r,
        pwm_one_pin_en_r, pwm_zero_pin_en_r, div_pin_en_r, slow_crystal_low_power_r,
        sys_clk_from_lxt_r});
      chk("ctrl_aux", {5'h00, i == 3 || i == 4, i == 2, i == 0}, {4'h0, div_out_second_en_r,
        timer_clk_from_sys_r, div_out_first_en_r, fast_osc_stop_r});
    end
    acc(1'b1, `ADDR_CTRL_A, 8'h00);
    pwm2_pin_enable = 1'b1;
    tick(3);
    chk("timer_clk", 8'h01, {7'h00, timer_clk_from_sys_r});
    pwm2_pin_enable = 1'b0;
  endtask
  task automatic t_wdt_reset();
    acc(1'b1, `ADDR_BANK, 8'h01);
    ev(3'b001);
    reset(1'b0, 1'b1);
    rd(`ADDR_BANK, 8'h01, "bank_kept");
    rd(`ADDR_STATUS, 8'h10, "flags_kept");
    reset(1'b0, 1'b0);
    rd(`ADDR_BANK, 8'h00, "bank_rst");
    reset(1'b1, 1'b0);
    rd(`ADDR_STATUS, 8'h00, "flags_pu");
  endtask
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    tick(10);
    rst_b = 1'b1;
    t_reset();
    t_bank();
    t_flags();
    t_alu();
    t_ctrl();
    t_wdt_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
